// ===== hdl/ssq_network_state_query_block.sv
`timescale 1ns/10ps
// Behaviour
// [RULE1] Slot 0..11 sampled on trigger rise only
// [RULE2] Only a trigger rising edge starts query
// [RULE3] Busy rises in the edge-detect cycle
// [RULE4] Done rises on successful query completion
// [RULE5] Done drops when trigger falls
// [RULE6] Trigger already low: done for one cycle
// [RULE7] Busy drops when done/error/aborted rises
// [RULE8] Abort on interrupting command; pulse if low
// [RULE9] Aborted drops when trigger falls
// [RULE10] Error on invalid slot index
// [RULE11] Error drops when trigger falls
// [RULE12] Fault code 0B, 0C, or passthrough
// [RULE13] Fault code changes only on error/done rise
// [RULE14] Word 0: bit per station 0..15
// [RULE15] State words update only on done rise
// [RULE16] Bit set means failed or offline node
// [RULE17] Flags mutually exclusive, none while busy
module ssq_network_state_query_block (
    input  wire logic                  clk_in,
    input  wire logic                  srst_in,
    input  wire ssq_pkg::ssq_req_t     req_in,
    input  wire logic                  abort_cmd_in,
    input  wire ssq_pkg::ssq_rsp_t     rsp_in,
    input  wire logic [127:0]          node_fault_in,
    output logic                       query_start_out,
    output logic [15:0]                query_slot_out,
    output ssq_pkg::ssq_flags_t        flags_out,
    output logic [15:0]                fault_code_out,
    output logic [15:0]                node_state_out [ssq_pkg::NODE_WORDS]
);

    // ==========================================================
    // State
    // ==========================================================
    ssq_pkg::ssq_state_t state;
    ssq_pkg::ssq_state_t next_state;
    logic                exec_prev;
    logic                next_exec_prev;
    ssq_pkg::ssq_flags_t next_flags;
    logic [15:0]         next_fault_code;
    logic                next_query_start;
    logic [15:0]         next_query_slot;
    logic                rise;
    logic                fall;
    logic                slot_bad;
    logic                take_ok;
    logic                take_bad;
    logic                cut;
    logic                answer;
    logic                answer_ok;
    logic                answer_nosup;
    logic                finish;
    logic                load_nodes;

    // ==========================================================
    // Trigger history
    // ==========================================================
    // Previous level of the trigger, for both edges
    always_comb
    begin
        next_exec_prev = req_in.execute;
    end

    // Reset level equals the idle trigger, so no false edge
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            exec_prev <= 1'b0;
        end
        else
        begin
            exec_prev <= next_exec_prev;
        end
    end

    // Trigger edges against the previous cycle's level
    assign rise = req_in.execute & ~exec_prev; // [RULE2]
    assign fall = ~req_in.execute & exec_prev;

    // ==========================================================
    // Event decode
    // ==========================================================
    // One-hot state keeps each event a single gate deep
    always_comb
    begin
        slot_bad     = req_in.slot_index > ssq_pkg::SLOT_MAX; // [RULE1] [RULE10]
        take_ok      = 1'b0;
        take_bad     = 1'b0;
        cut          = 1'b0;
        answer       = 1'b0;
        answer_ok    = 1'b0;
        answer_nosup = 1'b0;
        if (state == ssq_pkg::ST_IDLE)
        begin
            // Rises in any other state are ignored
            take_ok  = rise & ~slot_bad; // [RULE2]
            take_bad = rise & slot_bad; // [RULE10]
        end
        if (state == ssq_pkg::ST_WAIT)
        begin
            // Abort outranks an answer landing in the same cycle
            cut          = abort_cmd_in; // [RULE8]
            answer       = ~abort_cmd_in & rsp_in.valid;
            answer_ok    = answer & ~rsp_in.no_support; // [RULE4]
            answer_nosup = answer & rsp_in.no_support; // [RULE12]
        end
        finish     = cut | answer;
        load_nodes = answer_ok; // [RULE15]
    end

    // ==========================================================
    // Control state and flags
    // ==========================================================
    // Flags stand in HOLD, or pulse once through PULS
    always_comb
    begin
        next_state = state;
        next_flags = flags_out;
        case (state)
            ssq_pkg::ST_IDLE:
            begin
                // A new edge clears any leftover flag from the last query
                if (take_ok)
                begin
                    next_flags      = '0;
                    next_flags.busy = 1'b1; // [RULE3]
                    next_state      = ssq_pkg::ST_WAIT;
                end
                else if (take_bad)
                begin
                    next_flags       = '0;
                    next_flags.error = 1'b1; // [RULE10]
                    next_state       = ssq_pkg::ST_HOLD;
                end
            end
            ssq_pkg::ST_WAIT:
            begin
                // Busy falls in the very edge a finishing flag rises
                if (finish)
                begin
                    next_flags         = '0; // [RULE7] [RULE17]
                    next_flags.aborted = cut; // [RULE8]
                    next_flags.error   = answer_nosup;
                    next_flags.done    = answer_ok; // [RULE4]
                    if (req_in.execute)
                    begin
                        next_state = ssq_pkg::ST_HOLD;
                    end
                    else
                    begin
                        next_state = ssq_pkg::ST_PULS; // [RULE6] [RULE8]
                    end
                end
            end
            ssq_pkg::ST_HOLD:
            begin
                // Flags stand until the trigger is released
                if (fall)
                begin
                    next_flags = '0; // [RULE5] [RULE9] [RULE11]
                    next_state = ssq_pkg::ST_IDLE;
                end
            end
            ssq_pkg::ST_PULS:
            begin
                // Trigger was already low: one-cycle flag
                next_flags = '0; // [RULE6] [RULE8]
                next_state = ssq_pkg::ST_IDLE;
            end
            default:
            begin
                next_flags = '0;
                next_state = ssq_pkg::ST_IDLE;
            end
        endcase
    end

    // State and flags registers
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            state     <= ssq_pkg::ST_IDLE;
            flags_out <= '0;
        end
        else
        begin
            state     <= next_state;
            flags_out <= next_flags;
        end
    end

    // ==========================================================
    // Fault code
    // ==========================================================
    // Moves only with an error or done rise; abort leaves it
    always_comb
    begin
        next_fault_code = fault_code_out;
        if (take_bad)
        begin
            next_fault_code = ssq_pkg::FAULT_BAD_PARAM; // [RULE12] [RULE13]
        end
        else if (answer_nosup)
        begin
            next_fault_code = ssq_pkg::FAULT_NO_SUPPORT; // [RULE12] [RULE13]
        end
        else if (answer_ok)
        begin
            next_fault_code = rsp_in.ctrl_fault; // [RULE12] [RULE13]
        end
    end

    // Fault code register
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            fault_code_out <= ssq_pkg::FAULT_NONE;
        end
        else
        begin
            fault_code_out <= next_fault_code;
        end
    end

    // ==========================================================
    // Request to the master module
    // ==========================================================
    // A bad slot never reaches the master, so no stray traffic
    always_comb
    begin
        next_query_start = take_ok;
        next_query_slot  = query_slot_out;
        if (take_ok)
        begin
            next_query_slot = req_in.slot_index; // [RULE1]
        end
    end

    // Start pulse and slot registers
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            query_start_out <= 1'b0;
            query_slot_out  <= ssq_pkg::WORD_ZERO;
        end
        else
        begin
            query_start_out <= next_query_start;
            query_slot_out  <= next_query_slot;
        end
    end

    // ==========================================================
    // Station state words, captured with done's rise
    // ==========================================================
    generate
        for (genvar w = 0; w < ssq_pkg::NODE_WORDS; w++)
        begin : g_word
            logic [15:0] next_word;

            // Bit n of word w is station 16*w+n; 1 means abnormal
            always_comb
            begin
                next_word = load_nodes ? node_fault_in[w*16 +: 16] // [RULE14] [RULE16]
                                       : node_state_out[w];       // [RULE15]
            end

            always_ff @(posedge clk_in)
            begin
                if (srst_in)
                begin
                    node_state_out[w] <= ssq_pkg::WORD_ZERO;
                end
                else
                begin
                    node_state_out[w] <= next_word;
                end
            end
        end
    endgenerate

endmodule : ssq_network_state_query_block

// ===== hdl/ssq_pkg.sv
package ssq_pkg;

    // ==========================================================
    // Request limits and fault codes
    // ==========================================================
    localparam logic [15:0] SLOT_MAX         = 16'h000B;
    localparam logic [15:0] FAULT_NONE       = 16'h0000;
    localparam logic [15:0] FAULT_BAD_PARAM  = 16'h000B;
    localparam logic [15:0] FAULT_NO_SUPPORT = 16'h000C;
    localparam logic [15:0] WORD_ZERO        = 16'h0000;
    localparam int          NODE_WORDS       = 8;

    // ==========================================================
    // Request from the user program
    // ==========================================================
    typedef struct packed {
        logic        execute;
        logic [15:0] slot_index;
    } ssq_req_t;

    // ==========================================================
    // Answer from the master module in the addressed slot
    // ==========================================================
    typedef struct packed {
        logic        valid;
        logic        no_support;
        logic [15:0] ctrl_fault;
    } ssq_rsp_t;

    // ==========================================================
    // Status flags back to the user program
    // ==========================================================
    typedef struct packed {
        logic done;
        logic busy;
        logic aborted;
        logic error;
    } ssq_flags_t;

    // One-hot control states
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_WAIT = 4'h2,
        ST_HOLD = 4'h4,
        ST_PULS = 4'h8
    } ssq_state_t;

endpackage : ssq_pkg

// ===== tb/ssq_master_model.sv
`timescale 1ns/10ps
// ====================
// Answering master module
module ssq_master_model (
    input  wire logic          clk_in,
    input  wire logic          srst_in,
    input  wire logic          start_in,
    input  wire logic          abort_in,
    input  wire logic [3:0]    lat_in,
    input  wire logic          nosup_in,
    input  wire logic [15:0]   fault_in,
    input  wire logic [127:0]  nodes_in,
    output ssq_pkg::ssq_rsp_t  rsp_out,
    output logic [127:0]       nodes_out
);
    logic [4:0] cnt;
    logic       hit;
    // Latency count; an abort cancels the answer
    always_ff @(posedge clk_in)
        if (srst_in || abort_in)
            cnt <= 5'h00;
        else if (start_in)
            cnt <= {1'b0, lat_in} + 5'h01;
        else if (cnt != 5'h00)
            cnt <= cnt - 5'h01;
    // Outside the answer the data lines toggle
    assign hit       = (cnt == 5'h01);
    assign rsp_out   = '{valid: hit, no_support: hit & nosup_in,
                         ctrl_fault: hit ? fault_in : ~fault_in};
    assign nodes_out = hit ? nodes_in : ~nodes_in;
endmodule : ssq_master_model

// ===== tb/ssq_sva.sv
`timescale 1ns/10ps
// ====================
// Protocol checker
module ssq_sva (
    input wire logic                clk_in,
    input wire logic                srst_in,
    input wire ssq_pkg::ssq_req_t   req_in,
    input wire logic                abort_cmd_in,
    input wire ssq_pkg::ssq_rsp_t   rsp_in,
    input wire logic [127:0]        node_fault_in,
    input wire logic                query_start_out,
    input wire ssq_pkg::ssq_flags_t flags_out,
    input wire logic [15:0]         fault_code_out,
    input wire logic [15:0]         node_state_out [ssq_pkg::NODE_WORDS]
);
    // Single domain, so one clock and one disable
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (srst_in);

    property p_start;
        $rose(req_in.execute) && flags_out == 4'h0 && req_in.slot_index <= 16'h000B
        |=> flags_out == 4'h4 && query_start_out;
    endproperty
    a_start: assert property (p_start) else $error("busy late");
    property p_bad;
        $rose(req_in.execute) && flags_out == 4'h0 && req_in.slot_index > 16'h000B
        |=> flags_out == 4'h1 && fault_code_out == 16'h000B;
    endproperty
    a_bad: assert property (p_bad) else $error("bad slot");
    property p_done;
        flags_out.busy && rsp_in.valid && !rsp_in.no_support && !abort_cmd_in
        |=> flags_out == 4'h8 && fault_code_out == $past(rsp_in.ctrl_fault)
            && node_state_out[0] == $past(node_fault_in[15:0]);
    endproperty
    a_done: assert property (p_done) else $error("done");
    property p_nosup;
        flags_out.busy && rsp_in.valid && rsp_in.no_support && !abort_cmd_in
        |=> flags_out == 4'h1 && fault_code_out == 16'h000C;
    endproperty
    a_nosup: assert property (p_nosup) else $error("no support");
    property p_abort;
        flags_out.busy && abort_cmd_in |=> flags_out == 4'h2;
    endproperty
    a_abort: assert property (p_abort) else $error("abort");
    property p_fall;
        $fell(req_in.execute) && !flags_out.busy |=> flags_out == 4'h0;
    endproperty
    a_fall: assert property (p_fall) else $error("flag kept");
    property p_excl;
        $onehot0(flags_out);
    endproperty
    a_excl: assert property (p_excl) else $error("flags overlap");
    // Fault code and word 0 may only move with a done or error rise
    property p_hold;
        !$rose(flags_out.done) && !$rose(flags_out.error)
        |-> $stable(fault_code_out) && $stable(node_state_out[0]);
    endproperty
    a_hold: assert property (p_hold) else $error("hold");
endmodule : ssq_sva

bind ssq_network_state_query_block ssq_sva u_sva (.clk_in, .srst_in, .req_in, .abort_cmd_in,
    .rsp_in, .node_fault_in, .query_start_out, .flags_out, .fault_code_out, .node_state_out);

// ===== tb/tb_ssq_network_state_query_block.sv
`timescale 1ns/10ps
module tb_ssq_network_state_query_block;
    logic                clk_in = 1'b0;
    logic                srst_in = 1'b1;
    ssq_pkg::ssq_req_t   req = '0;
    logic                abort_cmd = 1'b0;
    logic [3:0]          lat = 4'h0;
    logic                nosup = 1'b0;
    logic [15:0]         fault = 16'h0000;
    logic [127:0]        src = '0;
    logic [127:0]        en = '0;
    logic [15:0]         ecode = 16'h0000;
    logic [31:0]         seed = 32'hB71A3D76;
    ssq_pkg::ssq_rsp_t   rsp;
    logic [127:0]        nodes;
    logic                start;
    ssq_pkg::ssq_flags_t flags;
    logic [15:0]         code;
    logic [15:0]         slot_seen;
    logic [15:0]         state [ssq_pkg::NODE_WORDS];
    int                  failures = 0;
    int                  compares = 0;
    int                  cyc = 0;

    always #5 clk_in = ~clk_in;

    ssq_network_state_query_block u_ssq_network_state_query_block (.clk_in(clk_in),
        .srst_in(srst_in), .req_in(req), .abort_cmd_in(abort_cmd), .rsp_in(rsp),
        .node_fault_in(nodes), .query_start_out(start), .query_slot_out(slot_seen),
        .flags_out(flags), .fault_code_out(code), .node_state_out(state));
    ssq_master_model u_ssq_master_model (.clk_in(clk_in), .srst_in(srst_in), .start_in(start),
        .abort_in(abort_cmd), .lat_in(lat), .nosup_in(nosup), .fault_in(fault),
        .nodes_in(src), .rsp_out(rsp), .nodes_out(nodes));

    // ====================
    // Helpers
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : wrap_up

    // One query; keep holds the trigger high past the finish
    task automatic query(input logic [15:0] slot, input logic ns, input logic ab,
                         input logic keep);
        logic [31:0] r;
        logic        bad;
        logic [15:0] ef;
        int          k;
        r = xs();
        bad = slot > 16'h000B;
        ef = bad ? 16'h0001 : ab ? 16'h0002 : ns ? 16'h0001 : 16'h0008;
        req.execute = 1'b1;
        req.slot_index = slot;
        lat = r[3:0];
        nosup = ns;
        fault = r[31:16];
        src = {xs(), xs(), xs(), xs()};
        ecode = bad ? 16'h000B : ab ? ecode : ns ? 16'h000C : r[31:16];
        en = (bad || ab || ns) ? en : src;
        @(negedge clk_in);
        check(16'(flags), bad ? 16'h0001 : 16'h0004);
        if (!bad)
            check(slot_seen, slot);
        req.execute = keep;
        abort_cmd = ab;
        @(negedge clk_in);
        abort_cmd = 1'b0;
        for (k = 0; k < 40 && flags.busy === 1'b1; k++)
            @(negedge clk_in);
        check(16'(flags), (bad && !keep) ? 16'h0000 : ef);
        check(code, ecode);
        check(state[0], en[15:0]);
        check(state[7], en[127:112]);
        @(negedge clk_in);
        check(16'(flags), keep ? ef : 16'h0000);
        req.execute = 1'b0;
        @(negedge clk_in);
        check(16'(flags), 16'h0000);
    endtask : query

    // ====================
    // Corner cases, then random queries
    initial
    begin
        repeat (12) @(negedge clk_in);
        srst_in = 1'b0;
        query(16'h0000, 1'b0, 1'b0, 1'b1);
        query(16'h000B, 1'b0, 1'b0, 1'b0);
        query(16'h000C, 1'b0, 1'b0, 1'b1);
        query(16'hFFFF, 1'b0, 1'b0, 1'b0);
        query(16'h0005, 1'b1, 1'b0, 1'b1);
        query(16'h0003, 1'b0, 1'b1, 1'b0);
        query(16'h0009, 1'b0, 1'b1, 1'b1);
        // An abort while idle must leave the flags alone
        abort_cmd = 1'b1;
        @(negedge clk_in);
        abort_cmd = 1'b0;
        check(16'(flags), 16'h0000);
        repeat (40)
        begin
            seed = xs();
            query(seed[6:5] == 2'h0 ? seed[31:16] : {12'h000, seed[3:0]}, seed[7],
                  seed[8] & seed[9], seed[10]);
        end
        wrap_up();
    end

    // Hang guard
    always @(posedge clk_in)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            failures++;
            wrap_up();
        end
    end
endmodule : tb_ssq_network_state_query_block
